// ### bench/i2c_master_model.sv
// two-wire bus master model pacing an 800 ns bus clock from the system clock
`timescale 1ns/10ps

module i2c_master_model (
  // pacing clock
  input  wire logic i_sys_clk,
  // wire level of the data line
  input  wire logic i_sda,
  // master drive, high releases the line to the pull-up
  output logic      o_scl,
  output logic      o_sda
);
  // bus idles released, clock held high between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // quarter period of two clocks: each bus phase holds four clocks
  task automatic q(input int n);
    repeat (2 * n) @(negedge i_sys_clk);
  endtask

  // data moves mid-low so it never shifts while the clock is high
  task automatic bt(input logic b, output logic r);
    o_sda = b;
    q(1);
    o_scl = 1'b1;
    q(2);
    r = i_sda;
    o_scl = 1'b0;
    q(1);
  endtask

  // start or repeated start, entered with the clock high or low
  task automatic start_cond();
    o_sda = 1'b1;
    q(1);
    o_scl = 1'b1;
    q(2);
    o_sda = 1'b0;
    q(2);
    o_scl = 1'b0;
    q(1);
  endtask

  // stop leaves both lines released
  task automatic stop_cond();
    o_sda = 1'b0;
    q(1);
    o_scl = 1'b1;
    q(2);
    o_sda = 1'b1;
    q(2);
  endtask

  // byte out, most significant bit first, then the slave answer
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(d[i], r);
    end
    bt(1'b1, r);
    ack = ~r;
  endtask

  // write frame: pointer then nb data bytes, upper byte first
  task automatic write_frame(input logic [6:0] a, input logic [1:0] p, input int nb,
                             input logic [15:0] w, output logic ok);
    logic k;
    start_cond();
    send_byte({a, 1'b0}, ok);
    if (ok) begin
      send_byte({6'h00, p}, k);
      ok = k;
      for (int i = 0; i < nb; i++) begin
        send_byte(i == 0 ? w[15:8] : w[7:0], k);
        ok = ok & k;
      end
    end
    stop_cond();
  endtask

  // read frame: pointer set, repeated start, nb bytes, last one refused
  task automatic read_frame(input logic [6:0] a, input logic [1:0] p, input int nb,
                            output logic [15:0] w, output logic ok);
    logic       k;
    logic       r;
    logic [7:0] d;
    w = 16'h0000;
    start_cond();
    send_byte({a, 1'b0}, ok);
    send_byte({6'h00, p}, k);
    start_cond();
    send_byte({a, 1'b1}, k);
    ok = ok & k;
    for (int n = 0; n < nb; n++) begin
      for (int i = 7; i >= 0; i--) begin
        bt(1'b1, r);
        d[i] = r;
      end
      bt(n == nb - 1, r);
      w = {w[7:0], d};
    end
    stop_cond();
  endtask
endmodule

// ### bench/tb.sv
// self-checking bench: sensor core driven by the bus master model
`timescale 1ns/10ps
`include "temp_alarm_regs.svh"

module tb;
  localparam int CONV = 800;
  logic       clk;
  logic       rst_n;
  logic       m_scl;
  logic       m_sda;
  logic       sda_out;
  logic       sda_oe;
  logic       al_out;
  logic       al_oe;
  logic [2:0] strap;
  logic [8:0] code;
  int         err_total;
  int         n_checks;
  int         cyc;
  wire        sda_wire = m_sda & ~sda_oe;
  wire  [6:0] addr = {`TS_ADDR_BASE, strap};

  temp_alarm_core #(.CONV_CYCLES(CONV)) temp_alarm_core_inst (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_scl(m_scl), .i_sda(sda_wire),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr_strap_bit0(strap[0]),
    .i_addr_strap_bit1(strap[1]), .i_addr_strap_bit2(strap[2]), .i_temp_code(code),
    .o_alert_output_out(al_out), .o_alert_output_oe(al_oe));
  i2c_master_model i2c_master_model_inst (
    .i_sys_clk(clk), .i_sda(sda_wire), .o_scl(m_scl), .o_sda(m_sda));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // cycles since release, so probes land mid-period far from a conversion end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) cyc <= 0;
    else cyc <= cyc + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // cross n conversion ends, stopping at the next midpoint each time
  task automatic step_conv(input int n);
    repeat (n) begin
      @(negedge clk);
      while (cyc % CONV != CONV / 2) @(negedge clk);
    end
  endtask

  // pin seen through the pull-up; polarity set means active high
  task automatic alert_is(input logic act, input logic polar);
    chk({15'h0, ~al_oe}, {15'h0, ~(act ^ polar)}, "alert pin");
  endtask

  task automatic wr(input logic [1:0] p, input int nb, input logic [15:0] w);
    logic ok;
    i2c_master_model_inst.write_frame(addr, p, nb, w, ok);
    chk({15'h0, ok}, 16'h0001, "write ack");
  endtask

  task automatic rd(input logic [1:0] p, input int nb, input logic [15:0] exp);
    logic        ok;
    logic [15:0] w;
    i2c_master_model_inst.read_frame(addr, p, nb, w, ok);
    chk({15'h0, ok}, 16'h0001, "read ack");
    chk(w, exp, "read data");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    alert_is(1'b0, 1'b0);
    chk({14'h0, al_out, sda_out}, 16'h0000, "open drain values");
    rd(`TS_PTR_HYST, 2, `TS_HYST_RST);
    rd(`TS_PTR_OVER, 2, `TS_OVER_RST);
    rd(`TS_PTR_CFG, 1, {8'h00, `TS_CFG_RST});
  endtask

  // each strap setting answers its own address and ignores a neighbour
  task automatic t_strap();
    logic ok;
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      @(negedge clk);
      wr(`TS_PTR_TEMP, 0, 16'h0000);
      i2c_master_model_inst.write_frame(addr ^ 7'h03, 2'h0, 0, 16'h0, ok);
      chk({15'h0, ok}, 16'h0000, "foreign address ack");
    end
  endtask

  // negative codes must not trip an unsigned compare against the default limit
  task automatic t_temp();
    logic [8:0] tbl [8] = '{9'h0fa, 9'h032, 9'h001, 9'h000, 9'h1ff, 9'h1ce, 9'h1b0, 9'h192};
    foreach (tbl[i]) begin
      code = tbl[i];
      step_conv(2);
      alert_is(i == 0, 1'b0);
      rd(`TS_PTR_TEMP, 2, {tbl[i], 7'h00});
    end
    wr(`TS_PTR_TEMP, 2, 16'h1234);
    rd(`TS_PTR_TEMP, 2, {9'h192, 7'h00});
  endtask

  task automatic t_thresh();
    wr(`TS_PTR_OVER, 2, 16'h1234);
    rd(`TS_PTR_OVER, 2, 16'h1200);
    wr(`TS_PTR_HYST, 2, 16'hff80);
    rd(`TS_PTR_HYST, 2, 16'hff80);
    wr(`TS_PTR_OVER, 2, {9'h032, 7'h00});
    wr(`TS_PTR_HYST, 2, {9'h028, 7'h00});
  endtask

  // comparator mode, every queue depth, with equality cases at both limits
  task automatic t_fault();
    int depth [4] = '{1, 2, 4, 6};
    for (int f = 0; f < 4; f++) begin
      code = 9'h020;
      wr(`TS_PTR_CFG, 1, {3'h0, 2'(f), 3'h0, 8'h00});
      step_conv(2);
      code = 9'h032;
      step_conv(1);
      alert_is(1'b0, 1'b0);
      code = 9'h033;
      step_conv(depth[f] - 1);
      alert_is(1'b0, 1'b0);
      step_conv(1);
      alert_is(1'b1, 1'b0);
      code = 9'h028;
      step_conv(2);
      alert_is(1'b1, 1'b0);
      code = 9'h020;
      step_conv(1);
      alert_is(1'b0, 1'b0);
    end
  endtask

  // interrupt mode, active high: event held until a register read
  task automatic t_intr();
    code = 9'h020;
    wr(`TS_PTR_CFG, 1, 16'h0600);
    step_conv(2);
    alert_is(1'b0, 1'b1);
    code = 9'h033;
    step_conv(2);
    alert_is(1'b1, 1'b1);
    rd(`TS_PTR_CFG, 1, 16'h0006);
    alert_is(1'b0, 1'b1);
    step_conv(2);
    alert_is(1'b0, 1'b1);
    code = 9'h020;
    step_conv(2);
    alert_is(1'b1, 1'b1);
    rd(`TS_PTR_HYST, 1, 16'h0014);
    alert_is(1'b0, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    code = 9'h000;
    strap = 3'h5;
    err_total = 0;
    n_checks = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_strap();
    t_temp();
    t_thresh();
    t_fault();
    t_intr();
    summarize();
  end

  // tests need some 55k cycles; this margin only trips a hang
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    summarize();
  end
endmodule

// ### src/temp_alarm_core.sv
// temperature sensor core: two-wire slave, conversion timer, threshold alarm
// Operation
// [RQ1] acts as two-wire bus slave, master clock up to 400 kHz
// [RQ2] three strap inputs give the low three bits of the slave address
// [RQ3] conversions start at reset release and repeat without any command
// [RQ4] each finished conversion replaces the 16-bit temperature word
// [RQ5] top bit of temperature word is the sign, set for negative values
// [RQ6] temperature sits in bits 15..7, bits 6..0 carry nothing
// [RQ7] low bits 6..0 of temperature and thresholds read as zero
// [RQ8] result is 9 bits, half a degree Celsius per step
// [RQ9] reading temperature any time gives last result, conversion undisturbed
// [RQ10] after each conversion compare with thresholds and update alert
// [RQ11] two configuration bits set a fault queue of consecutive conversions
// [RQ12] queue codes 00,01,10,11 give depth 1,2,4,6; default 00
// [RQ13] polarity bit picks active high or low, default active low
// [RQ14] alert is open drain: pulled low or released
// [RQ15] alarm has comparator mode and interrupt mode
// [RQ16] interrupt mode raises an event when temperature exceeds over-limit
// [RQ17] comparator mode acts as thermostat between over-limit and hysteresis
// [RQ18] comparator alert releases on first conversion below hysteresis
// [RQ19] interrupt alert clears only when the host reads any register
// [RQ20] over-limit and hysteresis are 16-bit read/write registers
// [RQ21] thresholds keep written values, usable as general storage
// [RQ22] every register is reachable over the two-wire bus
`timescale 1ns/10ps

module temp_alarm_core #(
  parameter int CONV_CYCLES = `TS_CONV_TIME_US * `TS_CLK_MHZ
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // two-wire bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  // address straps, tied at board level
  input  wire logic       i_addr_strap_bit0,
  input  wire logic       i_addr_strap_bit1,
  input  wire logic       i_addr_strap_bit2,
  // converter result, two's complement half degrees
  input  wire logic [8:0] i_temp_code,
  // alert pin, open drain
  output logic            o_alert_output_out,
  output logic            o_alert_output_oe
);
  import temp_alarm_pkg::*;
  sensor_state_s st;
  sensor_state_s next_st;
  logic                      scl;
  logic                      sda;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      bus_start;
  logic                      bus_stop;
  logic                      conv_done;
  logic                      read_clear;
  logic [6:0]                my_addr;
  logic [2:0]                fq_depth;
  logic                      above_over;
  logic                      below_hyst;
  logic [7:0]                tx_byte;
  logic [`TS_CONV_CNT_W-1:0] conv_last;
  ////////////////////////////////////////////////////////////////////////////
  // derived terms; only the second synchroniser stage is looked at
  assign scl       = st.scl_sync[1];
  assign sda       = st.sda_sync[1];
  assign scl_rise  = scl & ~st.scl_d;
  assign scl_fall  = ~scl & st.scl_d;
  assign bus_start = scl & st.scl_d & st.sda_d & ~sda;
  assign bus_stop  = scl & st.scl_d & ~st.sda_d & sda;
  assign my_addr   = {`TS_ADDR_BASE, st.strap_sync[5:3]};                    // [RQ2]
  assign conv_last = `TS_CONV_CNT_W'(CONV_CYCLES - 1);
  assign conv_done = (st.conv_cnt == conv_last);
  // signed compare of the 9-bit codes, half degree steps
  assign above_over = $signed(i_temp_code) > $signed(st.over[15:7]);       // [RQ10] [RQ8]
  assign below_hyst = $signed(i_temp_code) < $signed(st.hyst[15:7]);       // [RQ10]
  // fault queue depth from the two configuration bits
  always_comb begin
    unique case (st.cfg[`TS_CFG_FQ_HI:`TS_CFG_FQ_LO])                      // [RQ12]
      2'h0: fq_depth = 3'h1;
      2'h1: fq_depth = 3'h2;
      2'h2: fq_depth = 3'h4;
      2'h3: fq_depth = 3'h6;
    endcase
  end
  // byte to send next: config repeats, 16-bit words go high then low
  assign tx_byte = (st.ptr == `TS_PTR_CFG) ? st.cfg :
                   (st.byte_idx[0] ? st.rd_word[7:0] : st.rd_word[15:8]);
  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole core
  always_comb begin
    next_st          = st;
    read_clear       = 1'b0;
    next_st.scl_sync = {st.scl_sync[0], i_scl};
    next_st.sda_sync = {st.sda_sync[0], i_sda};
    next_st.scl_d    = scl;
    next_st.sda_d    = sda;
    // straps are board pins, so they pass two flops like the bus lines
    next_st.strap_sync = {st.strap_sync[2:0], i_addr_strap_bit2, i_addr_strap_bit1,
                          i_addr_strap_bit0};
    // free-running conversion timer, never touched by bus traffic
    next_st.conv_cnt = conv_done ? '0 : st.conv_cnt + 1'b1;               // [RQ3] [RQ9]
    // bus slave; a stop or start anywhere wins over the byte machine
    if (bus_stop) begin
      next_st.fsm    = S_IDLE;
      next_st.sda_oe = 1'b0;
    end else if (bus_start) begin
      next_st.fsm      = S_ADDR;
      next_st.bitcnt   = 4'h0;
      next_st.byte_idx = 2'h0;
      next_st.sda_oe   = 1'b0;
    end else begin
      unique case (st.fsm)
        S_IDLE: ;
        S_ADDR: begin
          if (scl_rise) begin
            next_st.shift  = {st.shift[6:0], sda};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end
          if (scl_fall && st.bitcnt == 4'h8) begin
            if (st.shift[7:1] == my_addr) begin                              // [RQ2]
              next_st.fsm    = S_AACK;
              next_st.sda_oe = 1'b1;
              next_st.rw     = st.shift[0];
              if (st.shift[0]) begin
                // snapshot keeps the two bytes of one word coherent
                read_clear = 1'b1;                                           // [RQ19]
                unique case (st.ptr)
                  `TS_PTR_TEMP: next_st.rd_word = st.temp;                   // [RQ9] [RQ22]
                  `TS_PTR_CFG:  next_st.rd_word = {st.cfg, 8'h00};
                  `TS_PTR_HYST: next_st.rd_word = st.hyst;
                  `TS_PTR_OVER: next_st.rd_word = st.over;
                endcase
              end
            end else begin
              next_st.fsm = S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            next_st.bitcnt = 4'h0;
            if (st.rw) begin
              next_st.fsm      = S_RD;
              next_st.byte_idx = 2'h1;
              next_st.shift    = (st.ptr == `TS_PTR_CFG) ? st.cfg : st.rd_word[15:8];
              next_st.sda_oe   = (st.ptr == `TS_PTR_CFG) ? ~st.cfg[7] : ~st.rd_word[15];
            end else begin
              next_st.fsm    = S_WR;
              next_st.sda_oe = 1'b0;
            end
          end
        end
        S_WR: begin
          if (scl_rise) begin
            next_st.shift  = {st.shift[6:0], sda};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end
          if (scl_fall && st.bitcnt == 4'h8) begin
            next_st.fsm    = S_WACK;
            next_st.sda_oe = 1'b1;
            if (st.byte_idx != 2'h3) begin
              next_st.byte_idx = st.byte_idx + 2'h1;
            end
            unique case (st.byte_idx)
              2'h0: next_st.ptr = st.shift[1:0];
              2'h1: begin
                if (st.ptr == `TS_PTR_CFG) begin
                  next_st.cfg = st.shift & `TS_CFG_WMASK;
                end else begin
                  next_st.wr_hi = st.shift;
                end
              end
              2'h2: begin
                // both bytes land together; low data bits kept clear
                if (st.ptr == `TS_PTR_OVER) begin
                  next_st.over = {st.wr_hi, st.shift & `TS_DATA_MASK_LO};    // [RQ20] [RQ21] [RQ7]
                end else if (st.ptr == `TS_PTR_HYST) begin
                  next_st.hyst = {st.wr_hi, st.shift & `TS_DATA_MASK_LO};    // [RQ20] [RQ21] [RQ7]
                end
              end
              2'h3: ;
            endcase
          end
        end
        S_WACK: begin
          if (scl_fall) begin
            next_st.fsm    = S_WR;
            next_st.bitcnt = 4'h0;
            next_st.sda_oe = 1'b0;
          end
        end
        S_RD: begin
          if (scl_rise) begin
            next_st.bitcnt = st.bitcnt + 4'h1;
          end
          if (scl_fall) begin
            if (st.bitcnt == 4'h8) begin
              next_st.fsm    = S_RACK;
              next_st.sda_oe = 1'b0;
            end else begin
              next_st.shift  = {st.shift[6:0], 1'b0};
              next_st.sda_oe = ~st.shift[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            next_st.ack_ok = ~sda;
          end
          if (scl_fall) begin
            if (st.ack_ok) begin
              next_st.fsm      = S_RD;
              next_st.bitcnt   = 4'h0;
              next_st.shift    = tx_byte;
              next_st.sda_oe   = ~tx_byte[7];
              next_st.byte_idx = {1'b0, ~st.byte_idx[0]};
            end else begin
              next_st.fsm = S_IDLE;
            end
          end
        end
      endcase
    end
    // a register read drops an interrupt-mode alert
    if (read_clear && st.cfg[`TS_CFG_MODE_BIT]) begin
      next_st.alert_act = 1'b0;                                              // [RQ19]
    end
    // conversion result and alarm; applied after the read clear so a new
    // event in the same cycle is not lost
    if (conv_done) begin
      next_st.temp = {i_temp_code, 7'h00};                                   // [RQ4] [RQ5] [RQ6] [RQ7]
      if (!st.cfg[`TS_CFG_MODE_BIT]) begin
        // comparator: queue to trip, first sample below hysteresis releases
        if (!st.alert_act) begin                                             // [RQ17]
          if (above_over) begin
            if (st.fault_cnt + 3'h1 >= fq_depth) begin                       // [RQ11]
              next_st.alert_act = 1'b1;
              next_st.fault_cnt = 3'h0;
            end else begin
              next_st.fault_cnt = st.fault_cnt + 3'h1;
            end
          end else begin
            next_st.fault_cnt = 3'h0;
          end
        end else if (below_hyst) begin
          next_st.alert_act = 1'b0;                                          // [RQ18]
          next_st.fault_cnt = 3'h0;
        end
        next_st.hunt_high = 1'b1;
      end else begin
        // interrupt: alternate between hunting over-limit and hysteresis
        if (st.hunt_high ? above_over : below_hyst) begin                    // [RQ16] [RQ15]
          if (st.fault_cnt + 3'h1 >= fq_depth) begin                         // [RQ11]
            next_st.alert_act = 1'b1;
            next_st.hunt_high = ~st.hunt_high;
            next_st.fault_cnt = 3'h0;
          end else begin
            next_st.fault_cnt = st.fault_cnt + 3'h1;
          end
        end else begin
          next_st.fault_cnt = 3'h0;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // state register; reset gives power-up defaults
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st           <= '0;
      st.scl_sync  <= 2'h3;
      st.sda_sync  <= 2'h3;
      st.scl_d     <= 1'b1;
      st.sda_d     <= 1'b1;
      st.fsm       <= S_IDLE;
      st.cfg       <= `TS_CFG_RST;                                           // [RQ12] [RQ13]
      st.over      <= `TS_OVER_RST;
      st.hyst      <= `TS_HYST_RST;
      st.hunt_high <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  // open drain: only ever pull low; polarity picks when
  assign o_sda_out          = 1'b0;                                          // [RQ1]
  assign o_sda_oe           = st.sda_oe;
  assign o_alert_output_out = 1'b0;                                          // [RQ14]
  assign o_alert_output_oe  = st.alert_act ^ st.cfg[`TS_CFG_POL_BIT];        // [RQ13]
  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_addr_hit;
    st.fsm == S_ADDR && scl_fall && st.bitcnt == 4'h8 && st.shift[7:1] == my_addr
      && !bus_start && !bus_stop;
  endsequence
  property p_addr_ack;
    s_addr_hit |=> (st.fsm == S_AACK && o_sda_oe);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("no ack on own address"); // [RQ2]
  property p_temp_store;
    conv_done |=> st.temp == {$past(i_temp_code), 7'h00};
  endproperty
  a_temp_store: assert property (p_temp_store) else $error("result not stored"); // [RQ4]
  property p_low_zero;
    st.temp[6:0] == 7'h00 && st.over[6:0] == 7'h00 && st.hyst[6:0] == 7'h00;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low bits not zero"); // [RQ7]
  property p_conv_run;
    st.conv_cnt != conv_last |=> st.conv_cnt == $past(st.conv_cnt) + 1'b1;
  endproperty
  a_conv_run: assert property (p_conv_run) else $error("conversion timer stalled"); // [RQ3]
  property p_cmp_release;
    conv_done && !st.cfg[`TS_CFG_MODE_BIT] && st.alert_act && below_hyst
      |=> !st.alert_act && o_alert_output_oe == st.cfg[`TS_CFG_POL_BIT];
  endproperty
  a_cmp_release: assert property (p_cmp_release) else $error("alert not released"); // [RQ18]
  property p_int_clear;
    read_clear && st.cfg[`TS_CFG_MODE_BIT] && !conv_done |=> !st.alert_act;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("read did not clear alert"); // [RQ19]
  property p_alert_pin;
    o_alert_output_out == 1'b0 && o_alert_output_oe == (st.alert_act != st.cfg[2]);
  endproperty
  a_alert_pin: assert property (p_alert_pin) else $error("alert pin level wrong"); // [RQ13]
  property p_queue_hold;
    conv_done && !st.cfg[`TS_CFG_MODE_BIT] && !st.alert_act && above_over
      && (st.fault_cnt + 3'h1 < fq_depth) |=> !st.alert_act;
  endproperty
  a_queue_hold: assert property (p_queue_hold) else $error("alert tripped early"); // [RQ11]
  property p_alert_quiet;
    !conv_done && !read_clear |=> st.alert_act == $past(st.alert_act);
  endproperty
  a_alert_quiet: assert property (p_alert_quiet) else $error("alert moved"); // [RQ10]
endmodule

// ### src/temp_alarm_pkg.sv
// types shared by the sensor core: bus state machine and the module state record
`include "temp_alarm_regs.svh"

package temp_alarm_pkg;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_AACK = 7'h04,
    S_WR   = 7'h08,
    S_WACK = 7'h10,
    S_RD   = 7'h20,
    S_RACK = 7'h40
  } bus_state_e;

  typedef struct packed {
    logic [1:0]                  scl_sync;
    logic [1:0]                  sda_sync;
    logic [5:0]                  strap_sync;
    logic                        scl_d;
    logic                        sda_d;
    bus_state_e                  fsm;
    logic [3:0]                  bitcnt;
    logic [7:0]                  shift;
    logic [1:0]                  byte_idx;
    logic                        rw;
    logic                        ack_ok;
    logic                        sda_oe;
    logic [1:0]                  ptr;
    logic [7:0]                  cfg;
    logic [15:0]                 temp;
    logic [15:0]                 over;
    logic [15:0]                 hyst;
    logic [15:0]                 rd_word;
    logic [7:0]                  wr_hi;
    logic [`TS_CONV_CNT_W-1:0]   conv_cnt;
    logic                        alert_act;
    logic                        hunt_high;
    logic [2:0]                  fault_cnt;
  } sensor_state_s;

endpackage

// ### src/temp_alarm_regs.svh
// register offsets, field positions, reset values and timing counts of the sensor core
`ifndef TEMP_ALARM_REGS_SVH
`define TEMP_ALARM_REGS_SVH

// pointer values that select a register
`define TS_PTR_TEMP      2'h0
`define TS_PTR_CFG       2'h1
`define TS_PTR_HYST      2'h2
`define TS_PTR_OVER      2'h3

// configuration register fields
`define TS_CFG_MODE_BIT  1
`define TS_CFG_POL_BIT   2
`define TS_CFG_FQ_LO     3
`define TS_CFG_FQ_HI     4
`define TS_CFG_WMASK     8'h1f
`define TS_CFG_RST       8'h00

// threshold reset values, data held in bits 15..7
`define TS_OVER_RST      16'h5000
`define TS_HYST_RST      16'h4b00
`define TS_DATA_MASK_LO  8'h80

// upper four bits of the slave address, straps give the low three
`define TS_ADDR_BASE     4'h9

// conversion timing
`define TS_CLK_MHZ       10
`define TS_CONV_TIME_US  45000
`define TS_CONV_CNT_W    20

`endif
